/* hdl/tcc_pkg.sv */
package tcc_pkg;

  // Register offsets on the 8-bit special function bus
  localparam logic [7:0] TCC_CHAN_MODE_LOW_PAIR = 8'hc1;
  localparam logic [7:0] TCC_CHAN1_VALUE_LOW = 8'hc2;
  localparam logic [7:0] TCC_CHAN1_VALUE_HIGH = 8'hc3;
  localparam logic [7:0] TCC_CHAN2_VALUE_LOW = 8'hc4;
  localparam logic [7:0] TCC_CHAN2_VALUE_HIGH = 8'hc5;
  localparam logic [7:0] TCC_CHAN3_VALUE_LOW = 8'hc6;
  localparam logic [7:0] TCC_CHAN3_VALUE_HIGH = 8'hc7;
  localparam logic [7:0] TCC_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] TCC_CHAN_IRQ_CONTROL = 8'hc9;
  localparam logic [7:0] TCC_RELOAD_VALUE_LOW = 8'hca;
  localparam logic [7:0] TCC_RELOAD_VALUE_HIGH = 8'hcb;
  localparam logic [7:0] TCC_TIMER_COUNT_LOW = 8'hcc;
  localparam logic [7:0] TCC_TIMER_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] TCC_CHAN_MODE_HIGH_PAIR = 8'hd1;
  localparam logic [7:0] TCC_CHAN_OUT_LATCH = 8'hd2;

  // Per-channel value register addresses; channel 0 shares the reload register
  localparam logic [7:0] TCC_VAL_LO_ADDR [4] = '{TCC_RELOAD_VALUE_LOW, TCC_CHAN1_VALUE_LOW,
                                                 TCC_CHAN2_VALUE_LOW, TCC_CHAN3_VALUE_LOW};
  localparam logic [7:0] TCC_VAL_HI_ADDR [4] = '{TCC_RELOAD_VALUE_HIGH, TCC_CHAN1_VALUE_HIGH,
                                                 TCC_CHAN2_VALUE_HIGH, TCC_CHAN3_VALUE_HIGH};

  // Field positions
  localparam int TCC_PS_POS = 5;
  localparam int TCC_RS_POS = 3;
  localparam int TCC_IS_POS = 0;
  localparam int TCC_IRQ_EN_POS = 4;
  localparam int TCC_MODE_HI_POS = 4;
  localparam logic [7:0] TCC_RESET_VALUE = 8'h00;
  localparam logic [15:0] TCC_TIMER_MAX = 16'hffff;

  // Prescale divisions for codes 000 to 110; 111 falls back to the slowest
  localparam logic [4:0] TCC_DIV_1 = 5'h01;
  localparam logic [4:0] TCC_DIV_2 = 5'h02;
  localparam logic [4:0] TCC_DIV_4 = 5'h04;
  localparam logic [4:0] TCC_DIV_6 = 5'h06;
  localparam logic [4:0] TCC_DIV_8 = 5'h08;
  localparam logic [4:0] TCC_DIV_12 = 5'h0c;
  localparam logic [4:0] TCC_DIV_24 = 5'h18;
  localparam logic [4:0] TCC_DIV_TABLE [8] = '{TCC_DIV_1, TCC_DIV_2, TCC_DIV_4, TCC_DIV_6,
                                               TCC_DIV_8, TCC_DIV_12, TCC_DIV_24, TCC_DIV_24};

  // Reload selection codes
  localparam logic [1:0] TCC_RL_OFF = 2'h0;
  localparam logic [1:0] TCC_RL_RISE = 2'h1;
  localparam logic [1:0] TCC_RL_AUTO = 2'h2;
  localparam logic [1:0] TCC_RL_FALL = 2'h3;

  // Input selection codes
  localparam logic [1:0] TCC_IN_STOP = 2'h0;
  localparam logic [1:0] TCC_IN_PRESCALE = 2'h1;
  localparam logic [1:0] TCC_IN_EVENT = 2'h2;
  localparam logic [1:0] TCC_IN_GATED = 2'h3;

  // Channel modes
  typedef enum logic [2:0] {
    TCC_M_OFF, TCC_M_CMP_QUIET, TCC_M_CMP0, TCC_M_CMP1,
    TCC_M_CAP_RISE, TCC_M_CAP_FALL, TCC_M_CAP_BOTH, TCC_M_CAP_SW
  } tcc_mode_type;

endpackage

/* hdl/tcc_timer2.sv */
// Functional notes
// - Prescale field divides the clock by 1, 2, 4, 6, 8, 12 or 24.
// - Reload select: off, reload-pin rising edge, overflow auto, reload-pin falling edge.
// - Input select: stopped, prescaler, count-pin falling events, prescaler gated by count pin.
// - Event mode samples count pin each cycle, increments the cycle after a fall.
// - Gated mode: count pin level enables or blocks the prescaled increment.
// - Auto reload loads the full 16-bit reload register on each overflow.
// - Edge reload loads the reload register on the selected reload-pin transition.
// - Each channel has an interrupt enable; writing 1 enables its request.
// - Compare or capture sets a sticky channel flag; only software clears it.
// - All four channel requests combine onto the single timer interrupt.
// - Mode codes 000 off, 001 silent compare, 010 compare 0, 011 compare 1.
// - Mode codes 100 rise, 101 fall, 110 both edges, 111 software capture.
// - Four comparators each compare their channel value with the timer.
// - Compare result reaches the pin in the same cycle as the match.
// - Compare mode 0: pin goes high on match, low on overflow.
// - Compare mode 0: software writes to the pin latch are ignored.
// - Compare mode 1: overflow leaves the pin output unchanged.
// - Compare mode 1: software writes a shadow level, copied out on match.
// - Hardware capture latches the timer on the chosen channel pin edge.
// - Software capture: writing the low byte latches the timer, data discarded.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer2
  import tcc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic CLK_I, // System clock, 50 MHz
  input wire logic SYS_RST_I, // Synchronous reset, active high
  input wire logic [7:0] ADDR_I, // Register address
  input wire logic [7:0] WDATA_I, // Register write data
  input wire logic WR_I, // Write strobe
  input wire logic RD_I, // Read strobe
  output logic [7:0] RDATA_O, // Read data, one cycle after the strobe
  input wire logic TIMER_COUNT_PIN_I, // External count / gate pin
  input wire logic RELOAD_TRIGGER_PIN_I, // External reload pin
  input wire logic [NUM_CHAN-1:0] CHAN_PIN_I, // Channel pin levels
  output logic [NUM_CHAN-1:0] CHAN_PIN_O, // Channel pin drive level
  output logic [NUM_CHAN-1:0] CHAN_PIN_OE_O, // Channel pin drive enable
  output logic IRQ_O // Combined channel interrupt request
);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] timer;
  logic [2:0] prescale_select;
  logic [1:0] reload_select;
  logic [1:0] input_select;
  logic [NUM_CHAN-1:0] irq_enable;
  logic [NUM_CHAN-1:0] event_flag;
  tcc_mode_type chan_mode [NUM_CHAN];
  logic [15:0] chan_value [NUM_CHAN];
  logic [NUM_CHAN-1:0] out_latch;
  logic [NUM_CHAN-1:0] shadow;
  logic [4:0] pre_cnt;
  logic count_s, count_p, ext_s, ext_p, fall_seen, primed;
  logic [NUM_CHAN-1:0] chan_s, chan_p, eq_q;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  wire wr_tcon = WR_I && (ADDR_I == TCC_TIMER_CONTROL);
  wire wr_irqc = WR_I && (ADDR_I == TCC_CHAN_IRQ_CONTROL);
  wire wr_mlo = WR_I && (ADDR_I == TCC_CHAN_MODE_LOW_PAIR);
  wire wr_mhi = WR_I && (ADDR_I == TCC_CHAN_MODE_HIGH_PAIR);
  wire wr_tl = WR_I && (ADDR_I == TCC_TIMER_COUNT_LOW);
  wire wr_th = WR_I && (ADDR_I == TCC_TIMER_COUNT_HIGH);
  wire wr_latch = WR_I && (ADDR_I == TCC_CHAN_OUT_LATCH);

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling; inputs are synchronous so one stage plus a previous copy

  wire count_fall = count_p && !count_s;
  wire ext_rise = !ext_p && ext_s;
  wire ext_fall = ext_p && !ext_s;
  wire [NUM_CHAN-1:0] chan_rise = ~chan_p & chan_s;
  wire [NUM_CHAN-1:0] chan_fall = chan_p & ~chan_s;

  // Sample registers; the first sample after reset fills both stages, so an idle-high pin shows no phantom edge
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      count_s <= 1'b0;
      count_p <= 1'b0;
      ext_s <= 1'b0;
      ext_p <= 1'b0;
      chan_s <= '0;
      chan_p <= '0;
      fall_seen <= 1'b0;
      primed <= 1'b0;
    end else begin
      count_s <= TIMER_COUNT_PIN_I;
      count_p <= primed ? count_s : TIMER_COUNT_PIN_I;
      ext_s <= RELOAD_TRIGGER_PIN_I;
      ext_p <= primed ? ext_s : RELOAD_TRIGGER_PIN_I;
      chan_s <= CHAN_PIN_I;
      chan_p <= primed ? chan_s : CHAN_PIN_I;
      primed <= 1'b1;
      fall_seen <= count_fall; // Count lands one cycle after detection
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and increment selection

  wire [4:0] div_last = TCC_DIV_TABLE[prescale_select] - 5'h01;
  wire pre_tick = (pre_cnt >= div_last);
  logic inc;

  // Prescaler runs free; a code change keeps the current count and does not restart the period
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_tick ? 5'h00 : pre_cnt + 5'h01;
    end
  end

  // Increment source per input select
  always_comb begin
    case (input_select)
      TCC_IN_STOP: inc = 1'b0;
      TCC_IN_PRESCALE: inc = pre_tick;
      TCC_IN_EVENT: inc = fall_seen;
      TCC_IN_GATED: inc = pre_tick && count_s;
      default: inc = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer and reload

  wire overflow = inc && (timer == TCC_TIMER_MAX);
  wire reload = ((reload_select == TCC_RL_AUTO) && overflow)
             || ((reload_select == TCC_RL_RISE) && ext_rise)
             || ((reload_select == TCC_RL_FALL) && ext_fall);

  // Software writes win over reload, reload over increment
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      timer <= '0;
    end else if (wr_tl || wr_th) begin
      if (wr_tl) timer[7:0] <= WDATA_I;
      if (wr_th) timer[15:8] <= WDATA_I;
    end else if (reload) begin
      timer <= chan_value[0];
    end else if (inc) begin
      timer <= timer + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // Flag clear by writing 0; a same-cycle event still sets the flag
  wire [NUM_CHAN-1:0] chan_event;
  wire [NUM_CHAN-1:0] flag_keep = wr_irqc ? WDATA_I[NUM_CHAN-1:0] : {NUM_CHAN{1'b1}};
  wire [NUM_CHAN-1:0] next_flag = (event_flag & flag_keep) | chan_event;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prescale_select <= TCC_RESET_VALUE[2:0];
      reload_select <= TCC_RESET_VALUE[1:0];
      input_select <= TCC_RESET_VALUE[1:0];
      irq_enable <= '0;
      event_flag <= '0;
    end else begin
      if (wr_tcon) begin
        prescale_select <= WDATA_I[TCC_PS_POS +: 3];
        reload_select <= WDATA_I[TCC_RS_POS +: 2];
        input_select <= WDATA_I[TCC_IS_POS +: 2];
      end
      if (wr_irqc) irq_enable <= WDATA_I[TCC_IRQ_EN_POS +: NUM_CHAN];
      event_flag <= next_flag;
    end
  end

  assign IRQ_O = |(event_flag & irq_enable);

  ////////////////////////////////////////////////////////////////////////
  // Channels

  wire [NUM_CHAN-1:0] next_latch;
  wire [NUM_CHAN-1:0] next_shadow;
  wire [NUM_CHAN-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < NUM_CHAN; i++) begin : g_chan
      wire wr_lo = WR_I && (ADDR_I == TCC_VAL_LO_ADDR[i]);
      wire wr_hi = WR_I && (ADDR_I == TCC_VAL_HI_ADDR[i]);
      wire wr_mode = (i < 2) ? wr_mlo : wr_mhi;
      wire [2:0] mode_field = WDATA_I[((i % 2) * TCC_MODE_HI_POS) +: 3];
      wire is_cmp0 = (chan_mode[i] == TCC_M_CMP0);
      wire is_cmp1 = (chan_mode[i] == TCC_M_CMP1);
      wire is_cmp = is_cmp0 || is_cmp1 || (chan_mode[i] == TCC_M_CMP_QUIET);
      wire eq = (timer == chan_value[i]);
      wire cap_hw = ((chan_mode[i] == TCC_M_CAP_RISE) && chan_rise[i])
                 || ((chan_mode[i] == TCC_M_CAP_FALL) && chan_fall[i])
                 || ((chan_mode[i] == TCC_M_CAP_BOTH) && (chan_rise[i] || chan_fall[i]));
      wire cap_sw = (chan_mode[i] == TCC_M_CAP_SW) && wr_lo;

      // Match fires once on entry to equality, so a stopped timer does not retrigger
      assign hit[i] = is_cmp && eq && !eq_q[i];
      assign chan_event[i] = hit[i] || cap_hw || cap_sw;

      // Output latch: mode 0 set on match, clear on overflow; mode 1 takes the shadow
      assign next_latch[i] = is_cmp0 ? (hit[i] ? 1'b1 : (overflow ? 1'b0 : out_latch[i]))
                           : is_cmp1 ? (hit[i] ? shadow[i] : out_latch[i])
                           : (wr_latch ? WDATA_I[i] : out_latch[i]);
      assign next_shadow[i] = (is_cmp1 && wr_latch) ? WDATA_I[i] : shadow[i];

      // Pin follows the match in the same cycle, ahead of the latch update
      assign CHAN_PIN_O[i] = hit[i] ? (is_cmp0 ? 1'b1 : (is_cmp1 ? shadow[i] : out_latch[i]))
                                    : out_latch[i];
      assign CHAN_PIN_OE_O[i] = is_cmp0 || is_cmp1;

      // Mode field and value register; a capture beats the written data
      always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
          chan_mode[i] <= TCC_M_OFF;
          chan_value[i] <= '0;
        end else begin
          if (wr_mode) chan_mode[i] <= tcc_mode_type'(mode_field);
          if (cap_hw || cap_sw) begin
            chan_value[i] <= timer;
          end else begin
            if (wr_lo) chan_value[i][7:0] <= WDATA_I;
            if (wr_hi) chan_value[i][15:8] <= WDATA_I;
          end
        end
      end
    end
  endgenerate

  // Output latches, shadows and match history
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      out_latch <= '0;
      shadow <= '0;
      eq_q <= '0;
    end else begin
      out_latch <= next_latch;
      shadow <= next_shadow;
      for (int k = 0; k < NUM_CHAN; k++) begin
        eq_q[k] <= (timer == chan_value[k]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read back

  logic [7:0] rd_mux;

  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (ADDR_I)
      TCC_TIMER_CONTROL: rd_mux = {prescale_select, reload_select, 1'b0, input_select};
      TCC_CHAN_IRQ_CONTROL: rd_mux = {irq_enable, event_flag};
      TCC_CHAN_MODE_LOW_PAIR: rd_mux = {1'b0, chan_mode[1], 1'b0, chan_mode[0]};
      TCC_CHAN_MODE_HIGH_PAIR: rd_mux = {1'b0, chan_mode[3], 1'b0, chan_mode[2]};
      TCC_TIMER_COUNT_LOW: rd_mux = timer[7:0];
      TCC_TIMER_COUNT_HIGH: rd_mux = timer[15:8];
      TCC_RELOAD_VALUE_LOW: rd_mux = chan_value[0][7:0];
      TCC_RELOAD_VALUE_HIGH: rd_mux = chan_value[0][15:8];
      TCC_CHAN1_VALUE_LOW: rd_mux = chan_value[1][7:0];
      TCC_CHAN1_VALUE_HIGH: rd_mux = chan_value[1][15:8];
      TCC_CHAN2_VALUE_LOW: rd_mux = chan_value[2][7:0];
      TCC_CHAN2_VALUE_HIGH: rd_mux = chan_value[2][15:8];
      TCC_CHAN3_VALUE_LOW: rd_mux = chan_value[3][7:0];
      TCC_CHAN3_VALUE_HIGH: rd_mux = chan_value[3][15:8];
      TCC_CHAN_OUT_LATCH: rd_mux = {4'h0, out_latch};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  wire tw = wr_tl || wr_th;
  wire cmp0_ch1 = (chan_mode[1] == TCC_M_CMP0);

  a_auto_reload_load: assert property (
    (reload_select == TCC_RL_AUTO) && overflow && !tw |=> timer == $past(chan_value[0]))
    else $error("auto reload did not load the reload value");

  a_edge_reload_load: assert property (
    (reload_select == TCC_RL_FALL) && ext_p && !ext_s && !tw |=> timer == $past(chan_value[0]))
    else $error("falling reload edge did not load the timer");

  a_event_count_step: assert property (
    (input_select == TCC_IN_EVENT) && count_p && !count_s ##1 !tw && !reload
    |=> timer == $past(timer) + 16'h0001)
    else $error("event count did not increment one cycle after the fall");

  a_stopped_timer_hold: assert property (
    (input_select == TCC_IN_STOP) && !tw && !reload |=> timer == $past(timer))
    else $error("stopped timer moved");

  a_gate_block: assert property (
    (input_select == TCC_IN_GATED) && !count_s && !tw && !reload |=> timer == $past(timer))
    else $error("gated timer counted with gate low");

  a_flag_sticky: assert property (
    event_flag[1] && !(wr_irqc && !WDATA_I[1]) |=> event_flag[1])
    else $error("event flag dropped without a software clear");

  a_irq_follows_flag: assert property (
    chan_event[1] && irq_enable[1] ##1 irq_enable[1] |-> IRQ_O)
    else $error("enabled channel event gave no interrupt");

  a_cmp0_pin_match: assert property (
    cmp0_ch1 && hit[1] |-> CHAN_PIN_O[1] && CHAN_PIN_OE_O[1] ##1 out_latch[1])
    else $error("compare mode 0 match not on pin in same cycle");

  a_cmp0_overflow_low: assert property (
    cmp0_ch1 && overflow && !hit[1] |=> !out_latch[1])
    else $error("compare mode 0 output not cleared on overflow");

  a_cmp1_overflow_keep: assert property (
    (chan_mode[2] == TCC_M_CMP1) && overflow && !hit[2] |=> out_latch[2] == $past(out_latch[2]))
    else $error("compare mode 1 output changed on overflow");

  a_sw_capture_value: assert property (
    (chan_mode[0] == TCC_M_CAP_SW) && WR_I && (ADDR_I == TCC_RELOAD_VALUE_LOW)
    |=> chan_value[0] == $past(timer))
    else $error("software capture did not latch the timer");

  a_rise_capture_value: assert property (
    (chan_mode[3] == TCC_M_CAP_RISE) && !chan_p[3] && chan_s[3] |=> chan_value[3] == $past(timer))
    else $error("rising edge capture did not latch the timer");

  c_auto_reload: cover property ((reload_select == TCC_RL_AUTO) && overflow);
  c_cmp1_match: cover property ((chan_mode[2] == TCC_M_CMP1) && hit[2]);
  c_hw_capture: cover property ((chan_mode[3] == TCC_M_CAP_BOTH) && chan_fall[3]);
  c_irq_raised: cover property ($rose(IRQ_O));

endmodule // tcc_timer2

`default_nettype wire

/* bench/tcc_timer2_test.sv */
`timescale 1ns/1ps
`default_nettype none

module tcc_timer2_test
  import tcc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] rdata;
  logic cnt_pin = 1'b1;
  logic rl_pin = 1'b1;
  logic [3:0] ch_in = 4'h0;
  logic [3:0] ch_out;
  logic [3:0] ch_oe;
  logic irq;
  int mismatches = 0;
  int compares = 0;
  int n;
  logic [7:0] got;
  logic [7:0] d;
  logic [15:0] t;
  logic [15:0] t2;
  logic [15:0] r;
  logic [15:0] exp_v;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #10 clk = ~clk;

  tcc_timer2 #(.NUM_CHAN(4)) tcc_timer2_i (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(bus_wr), .RD_I(bus_rd), .RDATA_O(rdata), .TIMER_COUNT_PIN_I(cnt_pin),
    .RELOAD_TRIGGER_PIN_I(rl_pin), .CHAN_PIN_I(ch_in), .CHAN_PIN_O(ch_out), .CHAN_PIN_OE_O(ch_oe),
    .IRQ_O(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [7:0] ctl(input logic [2:0] ps, input logic [1:0] rs, input logic [1:0] is);
    return {ps, rs, 1'b0, is};
  endfunction

  // Codes 110 and 111 both give the slowest rate
  function automatic int div_of(input int c);
    case (c)
      0: return 1;
      1: return 2;
      2: return 4;
      3: return 6;
      4: return 8;
      5: return 12;
      default: return 24;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic seen);
    compares++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      mismatches++;
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle strobes; the task leaves one edge before any next strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk8(name, exp, got);
  endtask

  task automatic rchk16(input string name, input logic [7:0] lo, input logic [15:0] exp);
    rchk(name, lo, exp[7:0]);
    rchk(name, lo + 8'h01, exp[15:8]);
  endtask

  task automatic set_timer(input logic [15:0] v);
    wr(TCC_TIMER_COUNT_LOW, v[7:0]);
    wr(TCC_TIMER_COUNT_HIGH, v[15:8]);
  endtask

  // Bounded wait on a channel pin; running out ends the run
  task automatic wait_pin(input int ch, input logic lvl);
    int k;
    k = 0;
    #1;
    while (ch_out[ch] !== lvl && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1("channel pin", lvl, ch_out[ch]);
    if (k == 200) begin
      end_sim();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h6dbe));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values, gaps in the map read zero as well
    for (int a = 'hc0; a <= 'hd2; a++) begin
      rchk("reset value", 8'(a), 8'h00);
    end
    // Read back of random data; reserved bits read zero
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(TCC_VAL_LO_ADDR[i], d);
      rchk("value low", TCC_VAL_LO_ADDR[i], d);
      wr(TCC_VAL_HI_ADDR[i], ~d);
      rchk("value high", TCC_VAL_HI_ADDR[i], ~d);
    end
    d = 8'($urandom);
    wr(TCC_CHAN_MODE_HIGH_PAIR, d);
    rchk("mode pair", TCC_CHAN_MODE_HIGH_PAIR, d & 8'h77);
    wr(TCC_CHAN_MODE_HIGH_PAIR, 8'h00);
    wr(TCC_TIMER_CONTROL, d & 8'hfc);
    rchk("timer control", TCC_TIMER_CONTROL, d & 8'hf8);
    wr(TCC_TIMER_CONTROL, 8'h00);
    wr(TCC_CHAN_IRQ_CONTROL, 8'h00);
    wr(TCC_CHAN_IRQ_CONTROL, 8'hff);
    rchk("irq control", TCC_CHAN_IRQ_CONTROL, 8'hf0);
    chk1("irq idle", 1'b0, irq);
    wr(8'hd0, 8'hff);
    rchk("unmapped", 8'hd0, 8'h00);
    // Counting rate per prescale code, last pass with the timer stopped
    for (int c = 0; c < 9; c++) begin
      wr(TCC_TIMER_CONTROL, ctl(3'(c), 2'h0, (c == 8) ? 2'h0 : 2'h1));
      repeat (30) @(posedge clk);
      rd(TCC_TIMER_COUNT_LOW);
      d = got;
      repeat (46) @(posedge clk);
      rd(TCC_TIMER_COUNT_LOW);
      chk8("prescale step", (c == 8) ? 8'h00 : 8'(48 / div_of(c)), got - d);
    end
    // Gated mode: the count pin blocks, then passes the ticks
    cnt_pin <= 1'b0;
    wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'h0, 2'h3));
    for (int g = 0; g < 2; g++) begin
      repeat (5) @(posedge clk);
      rd(TCC_TIMER_COUNT_LOW);
      d = got;
      repeat (18) @(posedge clk);
      rd(TCC_TIMER_COUNT_LOW);
      chk8("gated step", (g == 1) ? 8'h14 : 8'h00, got - d);
      cnt_pin <= 1'b1;
    end
    // Event mode: one count per falling edge of the count pin
    wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'h0, 2'h2));
    rd(TCC_TIMER_COUNT_LOW);
    d = got;
    n = $urandom_range(8, 1);
    repeat (n) begin
      @(posedge clk);
      cnt_pin <= 1'b0;
      repeat (3) @(posedge clk);
      cnt_pin <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (5) @(posedge clk);
    rd(TCC_TIMER_COUNT_LOW);
    chk8("event count", 8'(n), got - d);
    // Overflow reload; low byte of zero keeps the high byte steady afterwards
    wr(TCC_TIMER_CONTROL, 8'h00);
    r = {8'($urandom), 8'h00};
    wr(TCC_RELOAD_VALUE_LOW, r[7:0]);
    wr(TCC_RELOAD_VALUE_HIGH, r[15:8]);
    set_timer(16'hfff8);
    wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'h2, 2'h1));
    repeat (20) @(posedge clk);
    wr(TCC_TIMER_CONTROL, 8'h00);
    rchk("auto reload", TCC_TIMER_COUNT_HIGH, r[15:8]);
    // Pin reload under every code, falling then rising edge
    r = 16'($urandom);
    wr(TCC_RELOAD_VALUE_LOW, r[7:0]);
    wr(TCC_RELOAD_VALUE_HIGH, r[15:8]);
    for (int s = 0; s < 4; s++) begin
      wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'(s), 2'h0));
      set_timer(16'h0000);
      rl_pin <= 1'b0;
      repeat (4) @(posedge clk);
      rchk16("fall reload", TCC_TIMER_COUNT_LOW, (s == 3) ? r : 16'h0000);
      set_timer(16'h0000);
      rl_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rchk16("rise reload", TCC_TIMER_COUNT_LOW, (s == 1) ? r : 16'h0000);
    end
    // Compare mode 0 on channel 1
    wr(TCC_TIMER_CONTROL, 8'h00);
    set_timer(16'h0000);
    wr(TCC_CHAN1_VALUE_LOW, 8'h10);
    wr(TCC_CHAN1_VALUE_HIGH, 8'h00);
    // Channel 0 in silent compare at 0x0008: flag only, pin left undriven
    wr(TCC_RELOAD_VALUE_LOW, 8'h08);
    wr(TCC_RELOAD_VALUE_HIGH, 8'h00);
    wr(TCC_CHAN_MODE_LOW_PAIR, 8'h21);
    wr(TCC_CHAN_IRQ_CONTROL, 8'h20);
    #1;
    chk1("chan1 enable", 1'b1, ch_oe[1]);
    chk1("chan0 quiet", 1'b0, ch_oe[0]);
    wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'h0, 2'h1));
    wait_pin(1, 1'b1);
    chk1("irq in hit cycle", 1'b0, irq);
    @(posedge clk);
    #1;
    chk1("irq after hit", 1'b1, irq);
    wr(TCC_CHAN_OUT_LATCH, 8'h00);
    #1;
    chk1("latch write high", 1'b1, ch_out[1]);
    set_timer(16'hfff0);
    wait_pin(1, 1'b0);
    wr(TCC_TIMER_CONTROL, 8'h00);
    wr(TCC_CHAN_OUT_LATCH, 8'h02);
    #1;
    chk1("latch write low", 1'b0, ch_out[1]);
    // Flags stay until written with zero; enable masks the request
    rchk("flag set", TCC_CHAN_IRQ_CONTROL, 8'h23);
    wr(TCC_CHAN_IRQ_CONTROL, 8'h02);
    #1;
    chk1("irq masked", 1'b0, irq);
    wr(TCC_CHAN_IRQ_CONTROL, 8'h22);
    #1;
    chk1("irq unmasked", 1'b1, irq);
    wr(TCC_CHAN_IRQ_CONTROL, 8'h20);
    rchk("flag cleared", TCC_CHAN_IRQ_CONTROL, 8'h20);
    chk1("irq cleared", 1'b0, irq);
    // Compare mode 1 on channel 2, shadow copied on match only
    wr(TCC_CHAN_MODE_LOW_PAIR, 8'h00);
    set_timer(16'h0000);
    wr(TCC_CHAN2_VALUE_LOW, 8'h20);
    wr(TCC_CHAN2_VALUE_HIGH, 8'h00);
    wr(TCC_CHAN_MODE_HIGH_PAIR, 8'h03);
    wr(TCC_CHAN_OUT_LATCH, 8'h04);
    #1;
    chk1("shadow held", 1'b0, ch_out[2]);
    wr(TCC_TIMER_CONTROL, ctl(3'h0, 2'h0, 2'h1));
    wait_pin(2, 1'b1);
    set_timer(16'hfff0);
    repeat (30) @(posedge clk);
    #1;
    chk1("overflow keeps", 1'b1, ch_out[2]);
    wr(TCC_TIMER_CONTROL, 8'h00);
    rchk("flag unmasked only", TCC_CHAN_IRQ_CONTROL, 8'h24);
    chk1("irq disabled chan", 1'b0, irq);
    // Hardware capture on channel 3, each edge kind, stopped timer
    wr(TCC_CHAN_IRQ_CONTROL, 8'h00);
    for (int m = 4; m < 7; m++) begin
      t = 16'($urandom);
      t2 = 16'($urandom);
      wr(TCC_CHAN3_VALUE_LOW, 8'h00);
      wr(TCC_CHAN3_VALUE_HIGH, 8'h00);
      set_timer(t);
      wr(TCC_CHAN_MODE_HIGH_PAIR, 8'(m << 4));
      ch_in[3] <= 1'b1;
      repeat (4) @(posedge clk);
      exp_v = (m != 5) ? t : 16'h0000;
      rchk16("capture rise", TCC_CHAN3_VALUE_LOW, exp_v);
      set_timer(t2);
      ch_in[3] <= 1'b0;
      repeat (4) @(posedge clk);
      exp_v = (m != 4) ? t2 : exp_v;
      rchk16("capture fall", TCC_CHAN3_VALUE_LOW, exp_v);
      rchk("capture flag", TCC_CHAN_IRQ_CONTROL, 8'h08);
      wr(TCC_CHAN_IRQ_CONTROL, 8'h00);
    end
    // Software capture on channel 0 through the reload register
    wr(TCC_CHAN_MODE_HIGH_PAIR, 8'h00);
    t = 16'($urandom);
    set_timer(t);
    wr(TCC_CHAN_MODE_LOW_PAIR, 8'h07);
    wr(TCC_RELOAD_VALUE_LOW, 8'h99);
    rchk16("software capture", TCC_RELOAD_VALUE_LOW, t);
    rchk("software flag", TCC_CHAN_IRQ_CONTROL, 8'h01);
    end_sim();
  end

endmodule // tcc_timer2_test

`default_nettype wire
